// file: hdl/clx_pkg.sv
// Shared constants and types for the clear-instruction execution block.
`default_nettype none
package clx_pkg;

  localparam int unsigned INSTR_W = 14;

  // Instruction cycle phases, Gray coded along the Q1-Q2-Q3-Q4 path.
  typedef enum logic [1:0] {
    CLX_Q1 = 2'h0,
    CLX_Q2 = 2'h1,
    CLX_Q3 = 2'h3,
    CLX_Q4 = 2'h2
  } clx_phase_t;

  localparam clx_phase_t PHASE_RST = CLX_Q1;

  typedef enum logic [1:0] {
    CLX_OP_NONE = 2'h0,
    CLX_OP_ZF   = 2'h1,
    CLX_OP_ZA   = 2'h3,
    CLX_OP_WK   = 2'h2
  } clx_op_t;

  // Program word layouts.
  localparam logic [INSTR_W-1:0] ZF_MASK  = 14'h3F80;
  localparam logic [INSTR_W-1:0] ZF_MATCH = 14'h0180;
  localparam logic [INSTR_W-1:0] ZA_MASK  = 14'h3F80;
  localparam logic [INSTR_W-1:0] ZA_MATCH = 14'h0100;
  localparam logic [INSTR_W-1:0] WK_WORD  = 14'h0064;
  localparam int unsigned        ADDR_LSB = 0;

  localparam logic [7:0] ZERO_BYTE  = 8'h00;
  localparam logic       FLAG_SET   = 1'h1;
  localparam logic       PULSE_RST  = 1'h0;
  localparam logic [6:0] ADDR_RST   = 7'h00;

endpackage
`default_nettype wire

// file: hdl/clx_phase_if.sv
// Carrier for the instruction-cycle phase between the sequencer and the executor.
`default_nettype none
interface clx_phase_if;
  clx_pkg::clx_phase_t phase;
  modport gen (output phase);
  modport use_side (input phase);
endinterface
`default_nettype wire

// file: hdl/clx_phase.sv
// Four-phase instruction cycle sequencer.
`default_nettype none
module clx_phase (
  input  wire logic   clk,
  input  wire logic   rstn,
  input  wire logic   en,
  clx_phase_if.gen    ph
);

  typedef struct packed {
    clx_pkg::clx_phase_t phase;
  } clx_seq_t;

  clx_seq_t st_q;
  clx_seq_t st_d;

  //////////////////////////////////////////////////////////////////////////////
  // Each enabled clock advances one phase.
  always_comb begin
    st_d = st_q;
    case (st_q.phase)
      clx_pkg::CLX_Q1: st_d.phase = clx_pkg::CLX_Q2;
      clx_pkg::CLX_Q2: st_d.phase = clx_pkg::CLX_Q3;
      clx_pkg::CLX_Q3: st_d.phase = clx_pkg::CLX_Q4;
      clx_pkg::CLX_Q4: st_d.phase = clx_pkg::CLX_Q1;
      default:         st_d.phase = clx_pkg::PHASE_RST;
    endcase
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q.phase <= clx_pkg::PHASE_RST;
    end else if (en) begin
      st_q <= st_d;
    end
  end

  assign ph.phase = st_q.phase;

endmodule
`default_nettype wire

// file: hdl/clx_exec.sv
// Execution of the file-clear, accumulator-clear and watchdog-kick instructions.
//
// Contract
// RULE1 - File clear writes 00h to the addressed register and sets zero flag.
// RULE2 - Accumulator clear loads 00h and sets zero flag, no register file access.
// RULE3 - Watchdog kick clears the watchdog counter and its prescaler.
// RULE4 - Watchdog kick sets both active-low status flags, other flags untouched.
// RULE5 - Each is one word, one cycle; results land in the fourth phase.
`default_nettype none
module clx_exec #(
  parameter int unsigned ADDR_W = 7,
  parameter int unsigned DATA_W = 8
) (
  input  wire logic                            clk,
  input  wire logic                            rstn,
  input  wire logic                            en,
  input  wire logic                            instr_valid,
  input  wire logic [clx_pkg::INSTR_W-1:0]     instr_word,
  output logic      [1:0]                      phase,
  output logic                                 busy,
  output logic                                 unknown_op,
  output logic                                 done,
  output logic                                 file_we,
  output logic      [ADDR_W-1:0]               file_addr,
  output logic      [DATA_W-1:0]               file_data,
  output logic                                 acc_we,
  output logic      [DATA_W-1:0]               acc_data,
  output logic                                 zero_we,
  output logic                                 zero_val,
  output logic                                 watchdog_counter_clr,
  output logic                                 prescaler_clr,
  output logic                                 expiry_flag_n_we,
  output logic                                 expiry_flag_n_val,
  output logic                                 sleep_flag_n_we,
  output logic                                 sleep_flag_n_val
);

  //////////////////////////////////////////////////////////////////////////////
  // Elaboration checks.
  // The address field fits a seven-bit operand and the data path is one byte.
  if (ADDR_W < 1 || ADDR_W > 7) begin : g_bad_addr
    $error("ADDR_W must lie between 1 and 7.");
  end
  if (DATA_W != 8) begin : g_bad_data
    $error("DATA_W must be 8.");
  end

  //////////////////////////////////////////////////////////////////////////////
  // State.
  // Every flop of the executor outside the phase sequencer sits in this one struct, frozen while en is low.
  typedef struct packed {
    clx_pkg::clx_op_t  op;
    logic [ADDR_W-1:0] addr;
    logic              busy;
    logic              unknown_op;
    logic              done;
    logic              file_we;
    logic [ADDR_W-1:0] file_addr;
    logic [DATA_W-1:0] file_data;
    logic              acc_we;
    logic [DATA_W-1:0] acc_data;
    logic              zero_we;
    logic              zero_val;
    logic              wdt_clr;
    logic              pre_clr;
    logic              exp_we;
    logic              exp_val;
    logic              slp_we;
    logic              slp_val;
  } clx_state_t;

  clx_state_t  st_q;
  clx_state_t  st_d;
  clx_phase_if ph_if ();

  //////////////////////////////////////////////////////////////////////////////
  // Phase sequencer.
  clx_phase u_phase (
    .clk  (clk),
    .rstn (rstn),
    .en   (en),
    .ph   (ph_if.gen)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Decoding.
  // File clear is matched before accumulator clear; the watchdog kick needs the exact word.
  function automatic clx_pkg::clx_op_t clx_decode(
    input logic [clx_pkg::INSTR_W-1:0] w
  );
    clx_pkg::clx_op_t r;
    r = clx_pkg::CLX_OP_NONE;
    if ((w & clx_pkg::ZF_MASK) == clx_pkg::ZF_MATCH) begin
      r = clx_pkg::CLX_OP_ZF;
    end else if ((w & clx_pkg::ZA_MASK) == clx_pkg::ZA_MATCH) begin
      r = clx_pkg::CLX_OP_ZA;
    end else if (w == clx_pkg::WK_WORD) begin
      r = clx_pkg::CLX_OP_WK;
    end
    return r;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Next state.
  always_comb begin
    st_d            = st_q;
    st_d.unknown_op = clx_pkg::PULSE_RST;
    st_d.done       = clx_pkg::PULSE_RST;
    st_d.file_we    = clx_pkg::PULSE_RST;
    st_d.acc_we     = clx_pkg::PULSE_RST;
    st_d.zero_we    = clx_pkg::PULSE_RST;
    st_d.wdt_clr    = clx_pkg::PULSE_RST;
    st_d.pre_clr    = clx_pkg::PULSE_RST;
    st_d.exp_we     = clx_pkg::PULSE_RST;
    st_d.slp_we     = clx_pkg::PULSE_RST;
    case (ph_if.phase)
      clx_pkg::CLX_Q1: begin
        // Only the first phase takes a word; later phases ignore instr_valid.
        st_d.op = clx_pkg::CLX_OP_NONE;
        if (instr_valid) begin
          st_d.op         = clx_decode(instr_word); // [RULE5]
          st_d.addr       = instr_word[clx_pkg::ADDR_LSB +: ADDR_W];
          st_d.busy       = 1'h1;
          st_d.unknown_op = (clx_decode(instr_word) == clx_pkg::CLX_OP_NONE);
        end
      end
      clx_pkg::CLX_Q2: begin
        // The accumulator and watchdog clears read nothing from the register file.
        st_d.op = st_q.op;
      end
      clx_pkg::CLX_Q3: begin
        // Strobes registered here stand during the fourth phase.
        st_d.busy = 1'h0;
        st_d.done = st_q.busy;                                  // [RULE5]
        case (st_q.op)
          clx_pkg::CLX_OP_ZF: begin
            st_d.file_we   = 1'h1;                              // [RULE1]
            st_d.file_addr = st_q.addr;                         // [RULE1]
            st_d.file_data = clx_pkg::ZERO_BYTE;                // [RULE1]
            st_d.zero_we   = 1'h1;                              // [RULE1]
            st_d.zero_val  = clx_pkg::FLAG_SET;                 // [RULE1]
          end
          clx_pkg::CLX_OP_ZA: begin
            st_d.acc_we   = 1'h1;                               // [RULE2]
            st_d.acc_data = clx_pkg::ZERO_BYTE;                 // [RULE2]
            st_d.zero_we  = 1'h1;                               // [RULE2]
            st_d.zero_val = clx_pkg::FLAG_SET;                  // [RULE2]
          end
          clx_pkg::CLX_OP_WK: begin
            st_d.wdt_clr = 1'h1;                                // [RULE3]
            st_d.pre_clr = 1'h1;                                // [RULE3]
            st_d.exp_we  = 1'h1;                                // [RULE4]
            st_d.exp_val = clx_pkg::FLAG_SET;                   // [RULE4]
            st_d.slp_we  = 1'h1;                                // [RULE4]
            st_d.slp_val = clx_pkg::FLAG_SET;                   // [RULE4]
          end
          default: begin
            st_d.op = clx_pkg::CLX_OP_NONE;
          end
        endcase
      end
      clx_pkg::CLX_Q4: begin
        // Strobes fall at the close of this phase, so each stands one enabled cycle.
        st_d.op = clx_pkg::CLX_OP_NONE;
      end
      default: begin
        st_d.op = clx_pkg::CLX_OP_NONE;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // Registers.
  // A low en holds every flop, so a strobe already up stretches until en returns.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_q.op         <= clx_pkg::CLX_OP_NONE;
      st_q.addr       <= clx_pkg::ADDR_RST[ADDR_W-1:0];
      st_q.busy       <= clx_pkg::PULSE_RST;
      st_q.unknown_op <= clx_pkg::PULSE_RST;
      st_q.done       <= clx_pkg::PULSE_RST;
      st_q.file_we    <= clx_pkg::PULSE_RST;
      st_q.file_addr  <= clx_pkg::ADDR_RST[ADDR_W-1:0];
      st_q.file_data  <= clx_pkg::ZERO_BYTE;
      st_q.acc_we     <= clx_pkg::PULSE_RST;
      st_q.acc_data   <= clx_pkg::ZERO_BYTE;
      st_q.zero_we    <= clx_pkg::PULSE_RST;
      st_q.zero_val   <= clx_pkg::FLAG_SET;
      st_q.wdt_clr    <= clx_pkg::PULSE_RST;
      st_q.pre_clr    <= clx_pkg::PULSE_RST;
      st_q.exp_we     <= clx_pkg::PULSE_RST;
      st_q.exp_val    <= clx_pkg::FLAG_SET;
      st_q.slp_we     <= clx_pkg::PULSE_RST;
      st_q.slp_val    <= clx_pkg::FLAG_SET;
    end else if (en) begin
      st_q <= st_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs.
  assign phase                = ph_if.phase;
  assign busy                 = st_q.busy;
  assign unknown_op           = st_q.unknown_op;
  assign done                 = st_q.done;
  assign file_we              = st_q.file_we;
  assign file_addr            = st_q.file_addr;
  assign file_data            = st_q.file_data;
  assign acc_we               = st_q.acc_we;
  assign acc_data             = st_q.acc_data;
  assign zero_we              = st_q.zero_we;
  assign zero_val             = st_q.zero_val;
  assign watchdog_counter_clr = st_q.wdt_clr;
  assign prescaler_clr        = st_q.pre_clr;
  assign expiry_flag_n_we     = st_q.exp_we;
  assign expiry_flag_n_val    = st_q.exp_val;
  assign sleep_flag_n_we      = st_q.slp_we;
  assign sleep_flag_n_val     = st_q.slp_val;

endmodule
`default_nettype wire

// file: test/clx_exec_asserts.sv
// Assertions for the clear-instruction executor.
`default_nettype none
module clx_exec_asserts #(
  parameter int unsigned ADDR_W = 7,
  parameter int unsigned DATA_W = 8
) (
  input wire logic                         clk,
  input wire logic                         rstn,
  input wire logic                         en,
  input wire logic                         instr_valid,
  input wire logic [clx_pkg::INSTR_W-1:0]  instr_word,
  input wire logic [1:0]                   phase,
  input wire logic                         done,
  input wire logic                         file_we,
  input wire logic [ADDR_W-1:0]            file_addr,
  input wire logic [DATA_W-1:0]            file_data,
  input wire logic                         acc_we,
  input wire logic [DATA_W-1:0]            acc_data,
  input wire logic                         zero_we,
  input wire logic                         zero_val,
  input wire logic                         watchdog_counter_clr,
  input wire logic                         prescaler_clr,
  input wire logic                         expiry_flag_n_we,
  input wire logic                         expiry_flag_n_val,
  input wire logic                         sleep_flag_n_we,
  input wire logic                         sleep_flag_n_val
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);
  logic       tk;
  logic [6:0] adr;
  assign tk  = en && instr_valid && phase == 2'h0;
  assign adr = instr_word[6:0];
  ////////////////////////////////////////////////////////////////////////////////
  property p_zf; file_we |-> file_data == '0 && zero_we && zero_val && !acc_we; endproperty
  a_zf: assert property (p_zf) else $error("file clear result wrong");
  property p_zfa; (tk && instr_word[13:7] == 7'h03) ##1 en [*2]
    |=> file_we && file_addr == $past(adr, 3); endproperty
  a_zfa: assert property (p_zfa) else $error("file clear address or timing wrong");
  property p_za; acc_we |-> acc_data == '0 && zero_we && zero_val && !file_we; endproperty
  a_za: assert property (p_za) else $error("accumulator clear result wrong");
  property p_zal; (tk && instr_word[13:7] == 7'h02) ##1 en [*2] |=> acc_we && !file_we;
  endproperty
  a_zal: assert property (p_zal) else $error("accumulator clear timing wrong");
  property p_wk; watchdog_counter_clr |-> prescaler_clr && expiry_flag_n_we && sleep_flag_n_we;
  endproperty
  a_wk: assert property (p_wk) else $error("watchdog kick strobes split");
  property p_wkl; (tk && instr_word == 14'h0064) ##1 en [*2] |=> watchdog_counter_clr;
  endproperty
  a_wkl: assert property (p_wkl) else $error("watchdog kick timing wrong");
  property p_fl; expiry_flag_n_we |-> expiry_flag_n_val && sleep_flag_n_val && !zero_we;
  endproperty
  a_fl: assert property (p_fl) else $error("status flag values wrong");
  property p_q4; zero_we || watchdog_counter_clr |-> phase == 2'h2 && done; endproperty
  a_q4: assert property (p_q4) else $error("result outside fourth phase");
  property p_one; en && (zero_we || watchdog_counter_clr) |=> !zero_we && !watchdog_counter_clr;
  endproperty
  a_one: assert property (p_one) else $error("result strobe too long");
  c_zf: cover property (file_we);
  c_za: cover property (acc_we);
  c_wk: cover property (watchdog_counter_clr);
endmodule
bind clx_exec clx_exec_asserts #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) clx_exec_asserts_inst (
  .clk, .rstn, .en, .instr_valid, .instr_word, .phase, .done, .file_we, .file_addr,
  .file_data, .acc_we, .acc_data, .zero_we, .zero_val, .watchdog_counter_clr, .prescaler_clr,
  .expiry_flag_n_we, .expiry_flag_n_val, .sleep_flag_n_we, .sleep_flag_n_val
);
`default_nettype wire

// file: test/clx_exec_tb.sv
// Self-checking bench for the clear-instruction executor.
`default_nettype none
module clx_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, en, instr_valid, busy, unknown_op, done, file_we, acc_we, zero_we;
  logic        zero_val, watchdog_counter_clr, prescaler_clr, expiry_flag_n_we;
  logic        expiry_flag_n_val, sleep_flag_n_we, sleep_flag_n_val;
  logic [13:0] instr_word;
  logic [1:0]  phase;
  logic [6:0]  file_addr, strb;
  logic [7:0]  file_data, acc_data;
  int          num_errors = 0;
  int          total_checks = 0;
  assign strb = {file_we, acc_we, zero_we, watchdog_counter_clr, prescaler_clr,
                 expiry_flag_n_we, sleep_flag_n_we};
  clx_exec clx_exec_inst (.clk, .rstn, .en, .instr_valid, .instr_word, .phase, .busy,
    .unknown_op, .done, .file_we, .file_addr, .file_data, .acc_we, .acc_data, .zero_we,
    .zero_val, .watchdog_counter_clr, .prescaler_clr, .expiry_flag_n_we, .expiry_flag_n_val,
    .sleep_flag_n_we, .sleep_flag_n_val);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic to_q1();
    for (int n = 0; n < 8 && phase !== 2'h0; n++) @(negedge clk);
    if (phase !== 2'h0) begin
      chk("phase timeout", 16'h0, phase);
      end_sim();
    end
  endtask
  // Runs one word through a full cycle, optionally stalling en in the second phase.
  task automatic exec(input logic [13:0] w, input int k, input int st);
    logic [6:0] tbl [4] = '{7'h00, 7'h50, 7'h30, 7'h0F};
    to_q1();
    instr_valid = 1'b1;
    instr_word = w;
    @(negedge clk);
    instr_valid = 1'b0;
    chk("busy", 16'h1, busy);
    chk("unknown_op", k == 0, unknown_op);
    if (st > 0) begin
      en = 1'b0;
      repeat (st) @(negedge clk);
      en = 1'b1;
    end
    chk("phase", 16'h1, phase);
    @(negedge clk);
    chk("busy q3", 16'h1, busy);
    @(negedge clk);
    chk("strobes", tbl[k], strb);
    chk("done", 16'hA, {phase, done, busy});
    chk("data", 16'h0, {file_data, acc_data});
    chk("values", 16'h7, {zero_val, expiry_flag_n_val, sleep_flag_n_val});
    if (k == 1) chk("file_addr", w[6:0], file_addr);
    @(negedge clk);
    chk("strobes off", 16'h0, {strb, done});
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_file();
    exec(14'h0180, 1, 0);
    exec(14'h01FF, 1, 0);
    exec(14'h01AA, 1, 2);
  endtask
  task automatic t_acc();
    exec(14'h0100, 2, 0);
    exec(14'h017F, 2, 1);
  endtask
  task automatic t_other();
    exec(14'h0064, 3, 0);
    exec(14'h0065, 0, 0);
    exec(14'h0080, 0, 0);
  endtask
  task automatic t_refuse();
    to_q1();
    @(negedge clk);
    instr_valid = 1'b1;
    instr_word = 14'h0064;
    repeat (3) begin
      @(negedge clk);
      chk("refused", 16'h0, {strb, done, busy});
    end
    instr_valid = 1'b0;
    @(negedge clk);
    chk("refused", 16'h0, {strb, done, busy});
  endtask
  task automatic t_reset();
    exec(14'h0180, 1, 0);
    instr_valid = 1'b1;
    instr_word = 14'h0064;
    @(negedge clk);
    instr_valid = 1'b0;
    @(negedge clk);
    rstn = 1'b0;
    @(negedge clk);
    chk("reset", 16'h0, {phase, strb, done});
    rstn = 1'b1;
    exec(14'h0064, 3, 0);
  endtask
  initial begin
    rstn = 1'b0;
    en = 1'b1;
    instr_valid = 1'b0;
    instr_word = 14'h0000;
    repeat (3) @(negedge clk);
    rstn = 1'b1;
    t_file();
    t_acc();
    t_other();
    t_refuse();
    t_reset();
    end_sim();
  end
endmodule
`default_nettype wire
